// file: design/ppd_defs.svh
// Register indices, field positions, reset values and counts of the pixel clock control
`ifndef PPD_DEFS_SVH
`define PPD_DEFS_SVH

// Register indices
`define PPD_IDX_LOOP_CONTROL      8'h01
`define PPD_IDX_LINE_DIV_LOW      8'h02
`define PPD_IDX_LINE_DIV_HIGH     8'h03
`define PPD_IDX_PHASE_OFFSET      8'h04
`define PPD_IDX_PHASE_RESOLUTION  8'h05

// Field positions
`define PPD_POST_SCALE_LSB        4
`define PPD_POST_SCALE_MSB        5
`define PPD_GAIN_LSB              0
`define PPD_GAIN_MSB              2
`define PPD_DIV_HIGH_MSB          3
`define PPD_OFFSET_MSB            5
`define PPD_RES_MSB               1

// Reset values
`define PPD_RST_POST_SCALE        2'h0
`define PPD_RST_GAIN              3'h0
`define PPD_RST_DIV_LOW           8'hFF
`define PPD_RST_DIV_HIGH          4'h0
`define PPD_RST_OFFSET            6'h00
`define PPD_RST_RES               2'h0

// Counts
`define PPD_LINE_EXTRA            8
`define PPD_DIV_WIDTH             12
`define PPD_RES_CODE_16           2'h0
`define PPD_RES_CODE_32           2'h1
`define PPD_RES_CODE_64           2'h3
`define PPD_OFFSET_MAX_16         6'h0F
`define PPD_OFFSET_MAX_32         6'h1F
`define PPD_OFFSET_MAX_64         6'h3F

`endif

// file: design/ppd_pkg.sv
// Types shared by the pixel clock control modules
package ppd_pkg;
  typedef logic [7:0]  ppd_byte_t;
  typedef logic [11:0] ppd_div_t;
  typedef logic [12:0] ppd_modulus_t;
  typedef logic [5:0]  ppd_offset_t;
  typedef logic [1:0]  ppd_code2_t;
  typedef enum logic [1:0] {
    PPD_LOAD_ON_RESET,
    PPD_LOAD_ON_LINE
  } ppd_load_mode_t;
endpackage

// file: design/ppd_line_counter.sv
// Feedback divider counter: one pulse per completed modulus of pixel ticks
`timescale 1ns/1ps
module ppd_line_counter
  import ppd_pkg::*;
#(
  parameter int MOD_WIDTH = 13
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // Control
  input  wire logic                 restart,
  input  wire logic                 pixelTick,
  input  wire logic [MOD_WIDTH-1:0] modulus,
  // Status
  output logic                      linePulse,
  output logic [MOD_WIDTH-1:0]      pixelCount
);

  generate
    if (MOD_WIDTH < 2) begin : g_bad_width
      $error("ppd_line_counter: MOD_WIDTH too small");
    end
  endgenerate

  logic [MOD_WIDTH-1:0] count_q;
  logic [MOD_WIDTH-1:0] count_d;
  logic                 pulse_q;
  wire                  lastTick = pixelTick && (count_q >= modulus - MOD_WIDTH'(1));

  assign count_d = lastTick ? '0 : count_q + MOD_WIDTH'(1);

  always_ff @(posedge core_clk) begin
    if (rst || restart) begin
      count_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= lastTick;
      if (pixelTick) begin
        count_q <= count_d;
      end
    end
  end

  assign linePulse  = pulse_q;
  assign pixelCount = count_q;

endmodule // ppd_line_counter

// file: design/ppd_pixel_pll_ctrl.sv
// Pixel clock generator control: post-scaler, gain, line divider and phase offset
`timescale 1ns/1ps
`include "ppd_defs.svh"
module ppd_pixel_pll_ctrl
  import ppd_pkg::*;
#(
  parameter int DIV_WIDTH = `PPD_DIV_WIDTH
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire ppd_byte_t  regIndex,
  input  wire ppd_byte_t  regWrData,
  output ppd_byte_t       regRdData,
  // Loop control
  input  wire logic       loopReset,
  input  wire logic       loadOnLine,
  // Clock and sync outputs
  output logic            pixelTick,
  output logic            pixelClk,
  output logic            recoveredSync,
  output logic            shiftedSync,
  // Analog controls
  output logic [7:0]      detectorGainSelect,
  output logic [7:0]      detectorGainMicroAmp,
  output ppd_offset_t     phaseOffsetEffective,
  output logic [6:0]      phaseElementCount,
  output logic [DIV_WIDTH:0] activeModulus
);

  localparam int MOD_W = DIV_WIDTH + 1;

  generate
    if (DIV_WIDTH != `PPD_DIV_WIDTH) begin : g_bad_width
      $error("ppd_pixel_pll_ctrl: DIV_WIDTH must match the register layout");
    end
  endgenerate

  // Decoders
  function automatic logic [4:0] scaleRatio(input ppd_code2_t code);
    scaleRatio = 5'h02 << code;
  endfunction

  function automatic ppd_offset_t offsetMax(input ppd_code2_t code);
    unique case (code)
      `PPD_RES_CODE_32: offsetMax = `PPD_OFFSET_MAX_32;
      `PPD_RES_CODE_64: offsetMax = `PPD_OFFSET_MAX_64;
      default:          offsetMax = `PPD_OFFSET_MAX_16;
    endcase
  endfunction

  function automatic logic [2:0] resShift(input ppd_code2_t code);
    unique case (code)
      `PPD_RES_CODE_32: resShift = 3'h5;
      `PPD_RES_CODE_64: resShift = 3'h6;
      default:          resShift = 3'h4;
    endcase
  endfunction

  // Register fields, reserved bits are not stored
  ppd_code2_t   postScale_q;
  logic [2:0]   gain_q;
  ppd_byte_t    divLow_q;
  logic [3:0]   divHigh_q;
  ppd_offset_t  offset_q;
  ppd_code2_t   res_q;
  ppd_byte_t    rdData_q;
  ppd_div_t     activeDiv_q;

  wire wrLoop   = regWrEn && (regIndex == `PPD_IDX_LOOP_CONTROL);
  wire wrDivLo  = regWrEn && (regIndex == `PPD_IDX_LINE_DIV_LOW);
  wire wrDivHi  = regWrEn && (regIndex == `PPD_IDX_LINE_DIV_HIGH);
  wire wrOffset = regWrEn && (regIndex == `PPD_IDX_PHASE_OFFSET);
  wire wrRes    = regWrEn && (regIndex == `PPD_IDX_PHASE_RESOLUTION);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      postScale_q <= `PPD_RST_POST_SCALE;
      gain_q      <= `PPD_RST_GAIN;
      divLow_q    <= `PPD_RST_DIV_LOW;
      divHigh_q   <= `PPD_RST_DIV_HIGH;
      offset_q    <= `PPD_RST_OFFSET;
      res_q       <= `PPD_RST_RES;
    end else begin
      if (wrLoop) begin
        postScale_q <= regWrData[`PPD_POST_SCALE_MSB:`PPD_POST_SCALE_LSB];
        gain_q      <= regWrData[`PPD_GAIN_MSB:`PPD_GAIN_LSB];
      end
      if (wrDivLo) begin
        divLow_q <= regWrData;
      end
      if (wrDivHi) begin
        divHigh_q <= regWrData[`PPD_DIV_HIGH_MSB:0];
      end
      if (wrOffset) begin
        offset_q <= regWrData[`PPD_OFFSET_MSB:0];
      end
      if (wrRes) begin
        res_q <= regWrData[`PPD_RES_MSB:0];
      end
    end
  end

  // Readback, unmapped indices read zero
  ppd_byte_t rdMux;
  assign rdMux =
    (regIndex == `PPD_IDX_LOOP_CONTROL)     ? {2'h0, postScale_q, 1'b0, gain_q} :
    (regIndex == `PPD_IDX_LINE_DIV_LOW)     ? divLow_q :
    (regIndex == `PPD_IDX_LINE_DIV_HIGH)    ? {4'h0, divHigh_q} :
    (regIndex == `PPD_IDX_PHASE_OFFSET)     ? {2'h0, offset_q} :
    (regIndex == `PPD_IDX_PHASE_RESOLUTION) ? {6'h00, res_q} : 8'h00;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdData_q <= 8'h00;
    end else if (regRdEn) begin
      rdData_q <= rdMux;
    end
  end
  assign regRdData = rdData_q;

  // Divider load timing
  ppd_load_mode_t loadMode;
  logic           linePulse;
  wire  ppd_div_t shadowDiv = {divHigh_q, divLow_q};
  assign loadMode = loadOnLine ? PPD_LOAD_ON_LINE : PPD_LOAD_ON_RESET;
  wire  loadNow   = (loadMode == PPD_LOAD_ON_LINE) ? linePulse : loopReset;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      activeDiv_q <= {`PPD_RST_DIV_HIGH, `PPD_RST_DIV_LOW};
    end else if (loadNow) begin
      activeDiv_q <= shadowDiv;
    end
  end

  // Post-scaler: one pixel tick per ratio oscillator cycles
  logic [4:0] scaleCnt_q;
  logic       pixelClk_q;
  wire  [4:0] ratio    = scaleRatio(postScale_q);
  wire        scaleEnd = (scaleCnt_q >= ratio - 5'h01);
  wire  [4:0] scaleNext = scaleEnd ? 5'h00 : scaleCnt_q + 5'h01;
  // Level follows the ratio in force next cycle, so a rewrite cannot leave it high at a tick
  wire  ppd_code2_t scaleCodeNext = wrLoop ?
      regWrData[`PPD_POST_SCALE_MSB:`PPD_POST_SCALE_LSB] : postScale_q;
  wire  [4:0] ratioNext = scaleRatio(scaleCodeNext);

  always_ff @(posedge core_clk) begin
    if (rst || loopReset) begin
      scaleCnt_q <= 5'h00;
      pixelClk_q <= 1'b0;
    end else begin
      scaleCnt_q <= scaleNext;
      pixelClk_q <= scaleNext < (ratioNext >> 1);
    end
  end
  assign pixelTick = scaleEnd;
  assign pixelClk  = pixelClk_q;

  // Line counter, modulus is divider plus eight
  wire [MOD_W-1:0] modulus = {1'b0, activeDiv_q} + MOD_W'(`PPD_LINE_EXTRA);

  ppd_line_counter #(
    .MOD_WIDTH (MOD_W)
  ) u_line (
    .core_clk   (core_clk),
    .rst        (rst),
    .restart    (loopReset),
    .pixelTick  (scaleEnd),
    .modulus    (modulus),
    .linePulse  (linePulse),
    .pixelCount ()
  );
  assign recoveredSync = linePulse;
  assign activeModulus = modulus;

  // Phase offset: clamp, then delay in oscillator cycles below one pixel period
  wire ppd_offset_t maxOff  = offsetMax(res_q);
  wire ppd_offset_t effOff  = (offset_q > maxOff) ? maxOff : offset_q;
  wire [10:0]       product = {5'h00, effOff} * {6'h00, ratio};
  wire [10:0]       delayW  = product >> resShift(res_q);
  wire [4:0]        delay   = delayW[4:0];

  logic [4:0] delayCnt_q;
  logic       delayBusy_q;
  logic       shifted_q;

  always_ff @(posedge core_clk) begin
    if (rst || loopReset) begin
      delayCnt_q  <= 5'h00;
      delayBusy_q <= 1'b0;
      shifted_q   <= 1'b0;
    end else begin
      shifted_q <= 1'b0;
      if (linePulse) begin
        shifted_q   <= (delay == 5'h00);
        delayBusy_q <= (delay != 5'h00);
        delayCnt_q  <= delay - 5'h01;
      end else if (delayBusy_q) begin
        if (delayCnt_q == 5'h00) begin
          shifted_q   <= 1'b1;
          delayBusy_q <= 1'b0;
        end else begin
          delayCnt_q <= delayCnt_q - 5'h01;
        end
      end
    end
  end
  assign shiftedSync = shifted_q;

  // Analog control outputs
  assign detectorGainSelect   = 8'h01 << gain_q;
  assign detectorGainMicroAmp = 8'h01 << gain_q;
  assign phaseOffsetEffective = effOff;
  assign phaseElementCount    = 7'h01 << resShift(res_q);

endmodule // ppd_pixel_pll_ctrl

// file: tb/ppd_pixel_pll_ctrl_asserts.sv
// Port-level checker for the pixel clock generator control
`timescale 1ns/1ps
module ppd_pixel_pll_ctrl_asserts
  import ppd_pkg::*;
#(
  parameter int DIV_WIDTH = 12
) (
  // Clock and reset
  input wire logic           core_clk,
  input wire logic           rst,
  // Register port
  input wire ppd_byte_t      regRdData,
  // Loop control
  input wire logic           loopReset,
  // Clock and sync
  input wire logic           pixelTick,
  input wire logic           pixelClk,
  input wire logic           recoveredSync,
  input wire logic           shiftedSync,
  // Analog controls
  input wire logic [7:0]     detectorGainSelect,
  input wire logic [7:0]     detectorGainMicroAmp,
  input wire ppd_offset_t    phaseOffsetEffective,
  input wire logic [6:0]     phaseElementCount,
  input wire logic [DIV_WIDTH:0] activeModulus
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_gain;
    $onehot(detectorGainSelect) && detectorGainSelect == detectorGainMicroAmp;
  endproperty
  a_gain: assert property (p_gain) else $error("gain select not one-hot");
  property p_sync_one;
    recoveredSync |=> !recoveredSync;
  endproperty
  a_sync_one: assert property (p_sync_one) else $error("sync longer than one cycle");
  property p_sync_cause;
    recoveredSync |-> $past(pixelTick);
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("sync without pixel tick");
  property p_shift;
    $rose(recoveredSync) && !loopReset |-> ##[1:16] (shiftedSync || loopReset);
  endproperty
  a_shift: assert property (p_shift) else $error("shifted sync too late");
  property p_offset_lim;
    {1'b0, phaseOffsetEffective} < phaseElementCount;
  endproperty
  a_offset_lim: assert property (p_offset_lim) else $error("offset above limit");
  property p_elem;
    phaseElementCount inside {7'h10, 7'h20, 7'h40};
  endproperty
  a_elem: assert property (p_elem) else $error("bad element count");
  property p_reset_vals;
    $past(rst) |-> activeModulus == 13'h107 && regRdData == 8'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
  property p_pixclk;
    pixelTick && !loopReset |-> !pixelClk ##1 pixelClk;
  endproperty
  a_pixclk: assert property (p_pixclk) else $error("pixel clock phase wrong");
  cover property (recoveredSync);
  cover property (shiftedSync && !recoveredSync);
  cover property (phaseElementCount == 7'h40);
endmodule // ppd_pixel_pll_ctrl_asserts

bind ppd_pixel_pll_ctrl ppd_pixel_pll_ctrl_asserts #(.DIV_WIDTH(DIV_WIDTH)) u_chk (.*);

// file: tb/ppd_host_model.sv
// Host model driving the indexed register port
`timescale 1ns/1ps
module ppd_host_model
  import ppd_pkg::*;
(
  // Clock
  input  wire logic      core_clk,
  // Register port
  output logic           regWrEn,
  output logic           regRdEn,
  output ppd_byte_t      regIndex,
  output ppd_byte_t      regWrData,
  input  wire ppd_byte_t regRdData
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regIndex = 8'h00;
    regWrData = 8'h00;
  end
  task automatic wr(input ppd_byte_t idx, input ppd_byte_t d);
    @(negedge core_clk);
    {regIndex, regWrData, regWrEn} = {idx, d, 1'b1};
    @(negedge core_clk);
    {regIndex, regWrData, regWrEn} = {~idx, ~d, 1'b0};
  endtask
  task automatic rd(input ppd_byte_t idx, output ppd_byte_t d);
    @(negedge core_clk);
    {regIndex, regRdEn} = {idx, 1'b1};
    @(negedge core_clk);
    {regIndex, regRdEn} = {~idx, 1'b0};
    @(negedge core_clk);
    d = regRdData;
  endtask
endmodule // ppd_host_model

// file: tb/ppd_pixel_pll_ctrl_bench.sv
// Self-checking bench for the pixel clock generator control
`timescale 1ns/1ps
module ppd_pixel_pll_ctrl_bench;
  import ppd_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic loopReset = 1'b0;
  logic loadOnLine = 1'b0;
  logic regWrEn, regRdEn, pixelTick, pixelClk, recoveredSync, shiftedSync;
  ppd_byte_t regIndex, regWrData, regRdData, rv;
  logic [7:0] gainSel, gainUa;
  ppd_offset_t offEff;
  logic [6:0] elemCnt;
  logic [12:0] actMod;
  int n_mismatch = 0;
  int comparisons = 0;
  int nc, nt;
  always #5 core_clk = ~core_clk;
  ppd_host_model u_ppd_host_model (.core_clk(core_clk), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regIndex(regIndex), .regWrData(regWrData), .regRdData(regRdData));
  ppd_pixel_pll_ctrl u_ppd_pixel_pll_ctrl (.core_clk(core_clk), .rst(rst),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regIndex(regIndex), .regWrData(regWrData),
    .regRdData(regRdData), .loopReset(loopReset), .loadOnLine(loadOnLine),
    .pixelTick(pixelTick), .pixelClk(pixelClk), .recoveredSync(recoveredSync),
    .shiftedSync(shiftedSync), .detectorGainSelect(gainSel), .detectorGainMicroAmp(gainUa),
    .phaseOffsetEffective(offEff), .phaseElementCount(elemCnt), .activeModulus(actMod));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cycles and ticks up to event: 0 tick, 1 sync, 2 shifted sync
  task automatic wt(input int sel);
    logic hit;
    nc = 0;
    nt = 0;
    hit = 1'b0;
    while (!hit) begin
      @(negedge core_clk);
      nc++;
      nt += int'(pixelTick === 1'b1);
      hit = sel == 0 ? pixelTick === 1'b1 : sel == 1 ? recoveredSync === 1'b1 : shiftedSync === 1'b1;
      if (nc > 5000) begin
        chk("timeout", 16'h0001, 16'h0000);
        results();
      end
    end
  endtask
  task automatic rchk(input ppd_byte_t idx, input ppd_byte_t exp);
    u_ppd_host_model.rd(idx, rv);
    chk($sformatf("reg %h", idx), {8'h00, rv}, {8'h00, exp});
  endtask
  task automatic lr();
    @(negedge core_clk) loopReset = 1'b1;
    @(negedge core_clk) loopReset = 1'b0;
  endtask
  ppd_byte_t rstv[6] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  ppd_byte_t mask[6] = '{8'h37, 8'hFF, 8'h0F, 8'h3F, 8'h03, 8'h00};
  ppd_byte_t offx[4] = '{8'h0F, 8'h1F, 8'h0F, 8'h3F};
  ppd_byte_t shx[3] = '{8'h00, 8'h20, 8'h3F};
  initial begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    chk("modulus", {3'h0, actMod}, 16'h0107);
    for (int i = 0; i < 6; i++) rchk(8'(i + 1), rstv[i]);
    $display("done: reset values");
    for (int i = 0; i < 6; i++) begin
      u_ppd_host_model.wr(8'(i + 1), 8'hFF);
      rchk(8'(i + 1), mask[i]);
    end
    $display("done: reserved bits");
    u_ppd_host_model.wr(8'h02, 8'h03);
    u_ppd_host_model.wr(8'h03, 8'h01);
    chk("modulus", {3'h0, actMod}, 16'h0107);
    lr();
    chk("modulus", {3'h0, actMod}, 16'h010B);
    wt(1);
    wt(1);
    chk("line ticks", 16'(nt), 16'h010B);
    @(negedge core_clk) loadOnLine = 1'b1;
    wt(1);
    u_ppd_host_model.wr(8'h02, 8'h00);
    u_ppd_host_model.wr(8'h03, 8'h00);
    chk("modulus", {3'h0, actMod}, 16'h010B);
    wt(1);
    @(negedge core_clk);
    chk("modulus", {3'h0, actMod}, 16'h0008);
    wt(1);
    wt(1);
    chk("line ticks", 16'(nt), 16'h0008);
    loadOnLine = 1'b0;
    $display("done: line divider");
    for (int p = 0; p < 4; p++) begin
      u_ppd_host_model.wr(8'h01, 8'(p << 4));
      lr();
      wt(0);
      wt(0);
      chk("tick period", 16'(nc), 16'(2 << p));
      chk("pixel clock low", {15'h0000, pixelClk}, 16'h0000);
      @(negedge core_clk);
      chk("pixel clock high", {15'h0000, pixelClk}, 16'h0001);
    end
    $display("done: post scaler");
    for (int g = 0; g < 8; g++) begin
      u_ppd_host_model.wr(8'h01, 8'(g));
      chk("gain", {8'h00, gainUa}, 16'(1 << g));
      chk("gain select", {8'h00, gainSel}, 16'(1 << g));
    end
    $display("done: gain");
    u_ppd_host_model.wr(8'h04, 8'h3F);
    for (int r = 0; r < 4; r++) begin
      u_ppd_host_model.wr(8'h05, 8'(r));
      chk("offset", {10'h000, offEff}, {8'h00, offx[r]});
      chk("elements", {9'h000, elemCnt}, 16'(16 << (r == 3 ? 2 : r % 2)));
    end
    $display("done: resolution");
    u_ppd_host_model.wr(8'h01, 8'h30);
    lr();
    for (int s = 0; s < 3; s++) begin
      u_ppd_host_model.wr(8'h04, shx[s]);
      wt(1);
      wt(2);
      chk("shift delay", 16'(nc), 16'((shx[s] * 16 >> 6) + 1));
    end
    $display("done: phase offset");
    results();
  end
endmodule // ppd_pixel_pll_ctrl_bench
